// ---- bench/sfep_host_model.sv ----
`timescale 1ns/1ps
module sfep_host_model (
    output logic       sck_o,
    output logic       cs_n_o,
    output logic [3:0] io_o
);
    initial
    begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        io_o   = 4'h5;
    end
    task automatic frame(input logic [7:0] b[$]);
        #3 cs_n_o = 1'b0;
        foreach (b[i])
            for (int k = 7; k >= 0; k--)
            begin
                #20 io_o = {~io_o[3:1], b[i][k]};
                #20 sck_o = 1'b1;
                #40 sck_o = 1'b0;
            end
        #40 cs_n_o = 1'b1;
        // released lines flip so stale data never looks valid
        io_o = ~io_o;
        #300;
    endtask : frame
    // quad all-phase frame: high nibble first, opcode too
    task automatic qframe(input logic [7:0] b[$]);
        #3 cs_n_o = 1'b0;
        foreach (b[i])
            for (int k = 1; k >= 0; k--)
            begin
                #20 io_o = b[i][4*k +: 4];
                #20 sck_o = 1'b1;
                #40 sck_o = 1'b0;
            end
        #40 cs_n_o = 1'b1;
        io_o = ~io_o;
        #300;
    endtask : qframe
endmodule : sfep_host_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import sfep_pkg::*;
    logic        clk_sys_i, rst_n_i, cyc, stb, we, done, fail, ack, req, sck, cs_n, pbv;
    logic [7:0]  adr, pb;
    logic [31:0] dat, seed, rdat;
    logic [1:0]  kind, size;
    logic [23:0] addr;
    logic [3:0]  io;
    logic [2:0]  busy;
    logic [63:0] exp_q[$];
    int          miscompares, total_checks;
    sfep_host_model HOST (.sck_o(sck), .cs_n_o(cs_n), .io_o(io));
    sfep_ctl DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_io_i(io), .op_req_o(req),
        .op_kind_o(kind), .op_size_o(size), .op_addr_o(addr), .op_done_i(done),
        .op_fail_i(fail), .prog_byte_o(pb), .prog_byte_vld_o(pbv));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s;
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // array stand-in: finishes each operation five cycles after the request
    always @(posedge clk_sys_i)
    begin
        done <= 1'b0;
        if (req)
            busy <= 3'd5;
        else if (busy != 3'd0)
        begin
            busy <= busy - 3'd1;
            done <= (busy == 3'd1);
        end
    end
    task automatic cmp(input logic [31:0] got);
        logic [63:0] e;
        total_checks++;
        e = exp_q.size() ? exp_q.pop_front() : 64'h0000_0000_FFFF_FFFF;
        if ((got & e[63:32]) !== e[31:0])
        begin
            miscompares++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, e[31:0]);
        end
    endtask : cmp
    always @(posedge clk_sys_i)
    begin
        if (ack === 1'b1 && we === 1'b0)
            cmp(rdat);
        if (req === 1'b1)
            cmp({4'h0, kind, size, addr});
        if (pbv === 1'b1)
            cmp({24'h00_0000, pb});
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_sys_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back({m, e});
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic erase(input logic [7:0] op, input logic [23:0] a, input logic x, input sfep_size_t s, input logic [23:0] ea);
        if (x)
            exp_q.push_back({32'h0FFF_FFFF, 4'h0, 2'b00, s, ea});
        HOST.frame('{8'h06});
        HOST.frame('{op, a[23:16], a[15:8], a[7:0]});
    endtask : erase
    task automatic tally_and_finish;
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #400_000;
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        {rst_n_i, cyc, stb, we, fail, done, busy, adr, dat} = '0;
        seed = xs(32'h0000_6a7d);
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
        wb(1'b1, 8'h08, 32'h0000_0001);
        erase(8'h20, {9'h0, seed[2:0], 12'h0}, 1, SZ_4K, {9'h0, seed[2:0], 12'h0});
        erase(8'h20, 24'h40_0000, 0, SZ_4K, 24'h0);
        erase(8'h52, 24'h00_0000, 0, SZ_4K, 24'h0);
        HOST.frame('{8'h04});
        rd(8'h00, 32'h0000_00FF, 32'h0000_0000);
        erase(8'hD8, 24'h00_0000, 1, SZ_32K, 24'h00_8000);
        wb(1'b1, 8'h08, 32'h0000_0002);
        erase(8'hD8, 24'h04_0000, 1, SZ_256K, 24'h04_0000);
        wb(1'b1, 8'h08, 32'h0000_0000);
        fail <= 1'b1;
        erase(8'hD8, 24'h10_0000, 1, SZ_64K, 24'h10_0000);
        rd(8'h00, 32'h0000_00FF, 32'h0000_0021);
        fail <= 1'b0;
        HOST.frame('{8'h30});
        rd(8'h00, 32'h0000_00FF, 32'h0000_0000);
        wb(1'b1, 8'h04, 32'h0000_0002);
        HOST.frame('{8'h06});
        HOST.frame('{8'h01, 8'h08});
        rd(8'h00, 32'h0000_00FF, 32'h0000_0008);
        rd(8'h04, 32'h0000_FFFF, 32'h0000_0002);
        wb(1'b1, 8'h04, 32'h0000_0003);
        wb(1'b1, 8'h04, 32'h0000_2C03);
        rd(8'h04, 32'h0000_FFFF, 32'h0000_0003);
        HOST.frame('{8'h06});
        HOST.frame('{8'h01, 8'h00});
        rd(8'h00, 32'h0000_00FF, 32'h0000_0008);
        erase(8'hD8, 24'hFF_0000, 0, SZ_64K, 24'h0);
        rd(8'h00, 32'h0000_00FF, 32'h0000_0029);
        HOST.frame('{8'h30});
        rd(8'h00, 32'h0000_00FF, 32'h0000_0008);
        wb(1'b1, 8'h08, 32'h0000_0004);
        exp_q.push_back({32'h0FFF_FFFF, 4'h0, 2'b00, SZ_64K, 24'h20_0000});
        HOST.qframe('{8'h06});
        HOST.qframe('{8'hD8, 8'h20, 8'h00, 8'h00});
        HOST.qframe('{8'hD0, 8'h20, 8'h00, 8'h00});
        rd(8'h00, 32'h0000_FFFF, 32'h0000_0408);
        exp_q.push_back({32'h0000_00FF, 32'h0000_00A5});
        exp_q.push_back({32'h0FFF_FFFF, 4'h0, 2'b01, SZ_64K, 24'h00_3000});
        HOST.qframe('{8'h06});
        HOST.qframe('{8'h02, 8'h00, 8'h30, 8'h00, 8'hA5});
        wb(1'b1, 8'h0C, 32'h0000_0009);
        wb(1'b1, 8'h0C, 32'h0000_0002);
        rd(8'h0C, 32'h0000_000F, 32'h0000_000B);
        wb(1'b1, 8'h08, 32'h0000_0000);
        rd(8'h08, 32'h0000_0007, 32'h0000_0004);
        repeat (20) @(posedge clk_sys_i);
        if (exp_q.size() != 0)
        begin
            miscompares++;
            $display("CHECK FAILED %0t expected results never seen", $time);
        end
        tally_and_finish();
    end
endmodule : tb_top

// ---- hdl/sfep_ctl.sv ----
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "sfep_defines.svh"
module sfep_ctl
    import sfep_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output wire logic [31:0] wb_dat_o,
    output wire logic        wb_ack_o,
    input  wire logic        spi_sck_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic [3:0]  spi_io_i,
    output wire logic        op_req_o,
    output wire logic [1:0]  op_kind_o,
    output wire logic [1:0]  op_size_o,
    output wire logic [23:0] op_addr_o,
    input  wire logic        op_done_i,
    input  wire logic        op_fail_i,
    output wire logic [7:0]  prog_byte_o,
    output wire logic        prog_byte_vld_o
);
    sfep_regs_t r;
    sfep_regs_t n;
    logic       frz;
    logic       otp_lock;
    logic       top;

    sfep_spi_if link ();

    sfep_spi_rx u_rx (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .spi_sck_i  (spi_sck_i),
        .spi_cs_n_i (spi_cs_n_i),
        .spi_io_i   (spi_io_i),
        .bus        (link)
    );

    function automatic logic in_param(input logic [23:0] a, input logic hi);
        in_param = hi ? (a >= `SFEP_PARAM_HI_BASE) : (a < `SFEP_PARAM_LO_END);
    endfunction : in_param

    function automatic logic is_prot(input logic [23:0] a, input logic [2:0] bp,
                                     input logic low);
        logic [24:0] span;
        span = `SFEP_ARRAY_TOP >> (3'd7 - bp);
        if (bp == 3'd0)
            is_prot = 1'b0;
        else if (low)
            is_prot = {1'b0, a} < span;
        else
            is_prot = {1'b0, a} >= (`SFEP_ARRAY_TOP - span);
    endfunction : is_prot

    function automatic logic same_sect(input logic [23:0] a, input logic [23:0] b,
                                       input sfep_size_t sz);
        unique case (sz)
            SZ_4K:   same_sect = a[23:12] == b[23:12];
            SZ_32K:  same_sect = a[23:15] == b[23:15];
            SZ_64K:  same_sect = a[23:16] == b[23:16];
            SZ_256K: same_sect = a[23:18] == b[23:18];
        endcase
    endfunction : same_sect

    assign frz       = r.config_one_volatile[`SFEP_CONFIG_ONE_VOLATILE_FREEZE];
    // a chosen guard mode freezes every one-time config bit
    assign otp_lock  = r.guard[`SFEP_GRD_PERSIST] | r.guard[`SFEP_GRD_PASSWD];
    assign top       = r.config_one_nonvolatile[`SFEP_CONFIG_ONE_NONVOLATILE_PARAM];
    assign link.quad = r.quad_all_phase_mode;

    always_comb
    begin
        logic       launch;
        logic       refuse;
        sfep_kind_t lk;
        sfep_size_t sz;
        logic [23:0] ea;
        logic [7:0] d1;
        logic [7:0] d2;
        launch   = 1'b0;
        refuse   = 1'b0;
        lk       = OP_ERASE;
        sz       = SZ_64K;
        ea       = r.addr;
        d1       = (r.cnt == 3'd2) ? r.addr[7:0] : r.addr[15:8];
        d2       = r.addr[7:0];
        n        = r;
        n.req    = 1'b0;
        n.pb_vld = 1'b0;
        n.ack    = 1'b0;
        n.rdata  = 32'h0000_0000;

        // classic single-cycle slave, one wait state, unmapped reads zero
        if (wb_cyc_i && wb_stb_i && !r.ack)
        begin
            n.ack = 1'b1;
            case (wb_adr_i)
                `SFEP_WB_STAT:  n.rdata = {13'h0000, r.status_one_nonvolatile_bp, r.sr2v, r.status_one_volatile};
                `SFEP_WB_CFG1:  n.rdata = {16'h0000, r.config_one_nonvolatile, 6'h00, r.config_one_volatile};
                `SFEP_WB_CFG3:  n.rdata = {29'h0000_0000, r.quad_all_phase_mode, r.map};
                `SFEP_WB_GUARD: n.rdata = {28'h000_0000, r.guard};
                `SFEP_WB_LAST:  n.rdata = {5'h00, r.last_size, r.last_ok, r.last_addr};
                default:        n.rdata = 32'h0000_0000;
            endcase
            if (wb_we_i && wb_adr_i == `SFEP_WB_CFG1)
            begin
                if (wb_sel_i[0])
                begin
                    // freeze only sets; reset is the way out
                    n.config_one_volatile[`SFEP_CONFIG_ONE_VOLATILE_FREEZE] = frz | wb_dat_i[0];
                    n.config_one_volatile[`SFEP_CONFIG_ONE_VOLATILE_QUAD]   = wb_dat_i[1];
                end
                if (wb_sel_i[1] && !frz && !otp_lock)
                    n.config_one_nonvolatile = r.config_one_nonvolatile | (wb_dat_i[15:8] & 8'h2C);
            end
            if (wb_we_i && wb_adr_i == `SFEP_WB_CFG3 && wb_sel_i[0] && !otp_lock)
            begin
                n.map = sfep_map_t'(wb_dat_i[1:0]);
                n.quad_all_phase_mode = wb_dat_i[2];
            end
            if (wb_we_i && wb_adr_i == `SFEP_WB_GUARD && wb_sel_i[0])
            begin
                if (!otp_lock)
                    n.guard[2:0] = r.guard[2:0] | wb_dat_i[2:0];
                n.guard[`SFEP_GRD_LOCK] = r.guard[`SFEP_GRD_LOCK] | wb_dat_i[3];
                if (!r.guard[`SFEP_GRD_PERM] && !wb_dat_i[3])
                    n.guard[`SFEP_GRD_LOCK] = 1'b0;
            end
        end

        if (link.byte_vld)
        begin
            n.cnt = (r.cnt == 3'd7) ? r.cnt : r.cnt + 3'd1;
            if (r.cnt == 3'd0)
                n.op = link.rx_byte;
            else if (r.cnt < 3'd4)
                n.addr = {r.addr[15:0], link.rx_byte};
            // program data in any lane mode
            if (r.op == `SFEP_OP_PROG && r.cnt >= 3'd4 && r.st == ST_STANDBY
                && r.status_one_volatile[`SFEP_SR1_WEL])
            begin
                n.pb_vld = 1'b1;
                n.pb     = link.rx_byte;
            end
        end

        if (link.cs_rise)
        begin
            n.cnt = 3'd0;
            if (r.cnt != 3'd0 && r.op == `SFEP_OP_CLSR && r.st != ST_BUSY)
            begin
                n.status_one_volatile[`SFEP_SR1_EERR] = 1'b0;
                n.status_one_volatile[`SFEP_SR1_PERR] = 1'b0;
                n.status_one_volatile[`SFEP_SR1_WIP]  = 1'b0;
                n.st                   = ST_STANDBY;
            end
            else if (r.cnt != 3'd0 && r.st == ST_STANDBY)
            begin
                case (r.op)
                    `SFEP_OP_WREN: n.status_one_volatile[`SFEP_SR1_WEL] = 1'b1;
                    `SFEP_OP_WRDI: n.status_one_volatile[`SFEP_SR1_WEL] = 1'b0;
                    `SFEP_OP_WRR:
                        if (r.status_one_volatile[`SFEP_SR1_WEL] && r.cnt >= 3'd2)
                        begin
                            n.status_one_volatile[`SFEP_SR1_WEL] = 1'b0;
                            if (!frz)
                            begin
                                n.status_one_volatile[`SFEP_SR1_BP_HI:`SFEP_SR1_BP_LO] = d1[4:2];
                                if (!r.config_one_nonvolatile[`SFEP_CONFIG_ONE_NONVOLATILE_BPV])
                                    n.status_one_nonvolatile_bp = d1[4:2];
                            end
                            if (r.cnt >= 3'd3)
                            begin
                                n.config_one_volatile[`SFEP_CONFIG_ONE_VOLATILE_QUAD] = d2[1];
                                if (!frz && !otp_lock)
                                    n.config_one_nonvolatile = r.config_one_nonvolatile | (d2 & 8'h2C);
                            end
                        end
                    `SFEP_OP_PARAM_ERASE:
                        if (r.status_one_volatile[`SFEP_SR1_WEL] && r.cnt >= 3'd4 && r.map == MAP_HYBRID
                            && in_param(r.addr, top))
                        begin
                            launch = 1'b1;
                            sz     = SZ_4K;
                        end
                    `SFEP_OP_BLK_ERASE:
                        if (r.status_one_volatile[`SFEP_SR1_WEL] && r.cnt >= 3'd4)
                        begin
                            launch = 1'b1;
                            if (r.map == MAP_UNI256)
                                sz = SZ_256K;
                            else if (r.map == MAP_HYBRID
                                     && r.addr[23:16] == (top ? 8'hFF : 8'h00))
                            begin
                                sz = SZ_32K;
                                ea = {r.addr[23:16], top ? `SFEP_HALF_LO : `SFEP_HALF_HI};
                            end
                        end
                    `SFEP_OP_PROG:
                        if (r.status_one_volatile[`SFEP_SR1_WEL] && r.cnt >= 3'd5)
                        begin
                            launch = 1'b1;
                            lk     = OP_PROG;
                        end
                    `SFEP_OP_OTP_PROG:
                        if (r.status_one_volatile[`SFEP_SR1_WEL] && r.cnt >= 3'd5)
                        begin
                            launch = 1'b1;
                            lk     = OP_OTP;
                            refuse = frz;
                        end
                    `SFEP_OP_EVAL:
                        if (r.cnt >= 3'd4)
                            n.sr2v[`SFEP_SR2_ESTAT] = r.last_ok
                                && same_sect(r.addr, r.last_addr, r.last_size);
                    // grouped small erase, legacy quad write: ignored
                    default: ;
                endcase
            end
        end

        if (launch)
        begin
            n.status_one_volatile[`SFEP_SR1_WEL] = 1'b0;
            n.status_one_volatile[`SFEP_SR1_WIP] = 1'b1;
            if (lk != OP_OTP)
                refuse = is_prot(ea, r.status_one_volatile[`SFEP_SR1_BP_HI:`SFEP_SR1_BP_LO],
                                 r.config_one_nonvolatile[`SFEP_CONFIG_ONE_NONVOLATILE_ORIGIN]);
            if (refuse)
            begin
                n.st = ST_FAULT;
                if (lk == OP_ERASE)
                    n.status_one_volatile[`SFEP_SR1_EERR] = 1'b1;
                else
                    n.status_one_volatile[`SFEP_SR1_PERR] = 1'b1;
            end
            else
            begin
                n.st       = ST_BUSY;
                n.req      = 1'b1;
                n.kind     = lk;
                n.size     = sz;
                n.req_addr = ea;
                if (lk == OP_ERASE)
                begin
                    // a lost erase stays marked incomplete
                    n.last_addr = ea;
                    n.last_size = sz;
                    n.last_ok   = 1'b0;
                end
            end
        end

        // internal failure; set comes after any clear
        if (r.st == ST_BUSY && op_done_i)
        begin
            if (op_fail_i)
            begin
                n.st = ST_FAULT;
                if (r.kind == OP_ERASE)
                    n.status_one_volatile[`SFEP_SR1_EERR] = 1'b1;
                else
                    n.status_one_volatile[`SFEP_SR1_PERR] = 1'b1;
            end
            else
            begin
                n.st                  = ST_STANDBY;
                n.status_one_volatile[`SFEP_SR1_WIP] = 1'b0;
                if (r.kind == OP_ERASE)
                    n.last_ok = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r       <= '0;
            r.st    <= ST_STANDBY;
            r.status_one_volatile  <= `SFEP_RST_SR1;
            r.config_one_nonvolatile <= `SFEP_RST_CONFIG_ONE_NONVOLATILE;
            r.guard <= `SFEP_RST_GUARD;
        end
        else
            r <= n;
    end

    assign wb_dat_o        = r.rdata;
    assign wb_ack_o        = r.ack;
    assign op_req_o        = r.req;
    assign op_kind_o       = r.kind;
    assign op_size_o       = r.size;
    assign op_addr_o       = r.req_addr;
    assign prog_byte_o     = r.pb;
    assign prog_byte_vld_o = r.pb_vld;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    property p_fault_hold;
        r.st == ST_FAULT |-> r.status_one_volatile[`SFEP_SR1_WIP]
            && (r.status_one_volatile[`SFEP_SR1_EERR] || r.status_one_volatile[`SFEP_SR1_PERR]);
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault without flags");
    property p_fail_flag;
        r.st == ST_BUSY && op_done_i && op_fail_i |=> r.st == ST_FAULT
            ##1 r.status_one_volatile[`SFEP_SR1_WIP];
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("failure not latched");
    property p_clear;
        link.cs_rise && r.cnt != 3'd0 && r.op == `SFEP_OP_CLSR && r.st != ST_BUSY
            |=> !r.status_one_volatile[`SFEP_SR1_EERR] && !r.status_one_volatile[`SFEP_SR1_PERR] && r.st == ST_STANDBY;
    endproperty
    a_clear: assert property (p_clear) else $error("clear-status failed");
    property p_freeze_bp;
        frz |=> $stable(r.status_one_volatile[`SFEP_SR1_BP_HI:`SFEP_SR1_BP_LO])
            && $stable(r.config_one_nonvolatile[`SFEP_CONFIG_ONE_NONVOLATILE_PARAM]) && $stable(r.config_one_nonvolatile[`SFEP_CONFIG_ONE_NONVOLATILE_ORIGIN]);
    endproperty
    a_freeze_bp: assert property (p_freeze_bp) else $error("frozen bit changed");
    property p_freeze_otp;
        frz |=> $stable(r.config_one_nonvolatile[`SFEP_CONFIG_ONE_NONVOLATILE_BPV]) && !(r.req && r.kind == OP_OTP);
    endproperty
    a_freeze_otp: assert property (p_freeze_otp) else $error("otp write while frozen");
    property p_small;
        r.req && r.size == SZ_4K |-> r.map == MAP_HYBRID && in_param(r.req_addr, top);
    endproperty
    a_small: assert property (p_small) else $error("bad small erase");
    property p_half;
        r.req && r.size == SZ_32K |-> r.map == MAP_HYBRID && !in_param(r.req_addr, top);
    endproperty
    a_half: assert property (p_half) else $error("half erase hits params");
    property p_big;
        r.req && r.kind == OP_ERASE && r.map == MAP_UNI256 |-> r.size == SZ_256K;
    endproperty
    a_big: assert property (p_big) else $error("wrong erase size");
    property p_single;
        link.cs_rise && r.op == `SFEP_OP_WRR && r.cnt == 3'd2 && !wb_cyc_i
            |=> $stable(r.config_one_nonvolatile) && $stable(r.config_one_volatile[`SFEP_CONFIG_ONE_VOLATILE_QUAD]);
    endproperty
    a_single: assert property (p_single) else $error("config changed by one byte");

    c_fault: cover property (r.st == ST_BUSY && op_done_i && op_fail_i);
    c_clear: cover property (r.st == ST_FAULT ##[1:400] r.st == ST_STANDBY);
    c_half:  cover property (r.req && r.size == SZ_32K);
    c_wrr1:  cover property (link.cs_rise && r.op == `SFEP_OP_WRR && r.cnt == 3'd2);
endmodule : sfep_ctl

// ---- hdl/sfep_defines.svh ----
`ifndef SFEP_DEFINES_SVH
`define SFEP_DEFINES_SVH
// Contract
// - program or erase failure, or protected target, raises error; operation stays incomplete.
// - on error set matching error flag and write_in_progress, both held at one.
// - clear-status command clears error flags and returns to standby.
// - freeze bit blocks block-protect bits, placement and origin bits.
// - freeze bit also locks protect volatility bit and one-time-program region.
// - small-sector erase accepted only on top or bottom 4k parameter sectors.
// - no 8k or 32k grouped small-sector erase commands.
// - 64k erase accepted under uniform 64k or hybrid sector map.
// - hybrid 64k erase over parameter block erases only the 32k remainder.
// - under uniform 256k map the block erase erases 256k.
// - register write with one data byte updates only the first status register.
// - selecting a guard scheme mode makes all one-time config bits permanent.
// - guard register bit makes persistent sector lock protection permanent.
// - erase-status command reports whether last erase of addressed sector completed.
// - quad all-phase mode moves instruction, address and data four bits wide.
// - legacy quad page write absent; normal program works in quad mode.
// - one command is everything sent during one chip select low interval.
// - first eight bits of each command are the instruction code.

`define SFEP_OP_WREN        8'h06
`define SFEP_OP_WRDI        8'h04
`define SFEP_OP_WRR         8'h01
`define SFEP_OP_CLSR        8'h30
`define SFEP_OP_PARAM_ERASE 8'h20
`define SFEP_OP_BLK_ERASE   8'hD8
`define SFEP_OP_PROG        8'h02
`define SFEP_OP_OTP_PROG    8'h42
`define SFEP_OP_EVAL        8'hD0

`define SFEP_SR1_WIP        0
`define SFEP_SR1_WEL        1
`define SFEP_SR1_BP_LO      2
`define SFEP_SR1_BP_HI      4
`define SFEP_SR1_EERR       5
`define SFEP_SR1_PERR       6
`define SFEP_SR2_ESTAT      2
`define SFEP_CONFIG_ONE_VOLATILE_FREEZE    0
`define SFEP_CONFIG_ONE_VOLATILE_QUAD      1
`define SFEP_CONFIG_ONE_NONVOLATILE_PARAM    2
`define SFEP_CONFIG_ONE_NONVOLATILE_BPV      3
`define SFEP_CONFIG_ONE_NONVOLATILE_ORIGIN   5
`define SFEP_GRD_PERM       0
`define SFEP_GRD_PERSIST    1
`define SFEP_GRD_PASSWD     2
`define SFEP_GRD_LOCK       3

`define SFEP_WB_STAT        8'h00
`define SFEP_WB_CFG1        8'h04
`define SFEP_WB_CFG3        8'h08
`define SFEP_WB_GUARD       8'h0C
`define SFEP_WB_LAST        8'h10

`define SFEP_RST_SR1        8'h00
`define SFEP_RST_CONFIG_ONE_NONVOLATILE      8'h00
`define SFEP_RST_GUARD      4'h0
`define SFEP_ARRAY_TOP      25'h100_0000
`define SFEP_PARAM_LO_END   24'h00_8000
`define SFEP_PARAM_HI_BASE  24'hFF_8000
`define SFEP_HALF_HI        16'h8000
`define SFEP_HALF_LO        16'h0000
`endif

// ---- hdl/sfep_pkg.sv ----
package sfep_pkg;
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_BUSY    = 3'b010,
        ST_FAULT   = 3'b100
    } sfep_state_t;
    typedef enum logic [1:0] {
        MAP_UNI64  = 2'b00,
        MAP_HYBRID = 2'b01,
        MAP_UNI256 = 2'b10
    } sfep_map_t;
    typedef enum logic [1:0] {
        SZ_4K   = 2'b00,
        SZ_32K  = 2'b01,
        SZ_64K  = 2'b10,
        SZ_256K = 2'b11
    } sfep_size_t;
    typedef enum logic [1:0] {
        OP_ERASE = 2'b00,
        OP_PROG  = 2'b01,
        OP_OTP   = 2'b10
    } sfep_kind_t;
    typedef struct packed {
        sfep_state_t st;
        logic [7:0]  status_one_volatile;
        logic [7:0]  sr2v;
        logic [2:0]  status_one_nonvolatile_bp;
        logic [1:0]  config_one_volatile;
        logic [7:0]  config_one_nonvolatile;
        sfep_map_t   map;
        logic        quad_all_phase_mode;
        logic [3:0]  guard;
        logic [7:0]  op;
        logic [2:0]  cnt;
        logic [23:0] addr;
        logic [23:0] last_addr;
        sfep_size_t  last_size;
        logic        last_ok;
        logic        req;
        sfep_kind_t  kind;
        sfep_size_t  size;
        logic [23:0] req_addr;
        logic        pb_vld;
        logic [7:0]  pb;
        logic        ack;
        logic [31:0] rdata;
    } sfep_regs_t;
endpackage : sfep_pkg

// ---- hdl/sfep_spi_if.sv ----
`timescale 1ns/1ps
interface sfep_spi_if;
    logic       quad;
    logic       byte_vld;
    logic [7:0] rx_byte;
    logic       cs_act;
    logic       cs_rise;
    modport rx  (input quad, output byte_vld, rx_byte, cs_act, cs_rise);
    modport ctl (output quad, input byte_vld, rx_byte, cs_act, cs_rise);
endinterface : sfep_spi_if

// ---- hdl/sfep_spi_rx.sv ----
`timescale 1ns/1ps
module sfep_spi_rx (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       spi_sck_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic [3:0] spi_io_i,
    sfep_spi_if.rx          bus
);
    logic [5:0] s1;
    logic [5:0] s2;
    logic       sck_q;
    logic       cs_q;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [3:0] bits;
    logic [3:0] next_bits;
    logic       vld;
    logic       next_vld;
    logic [7:0] data;
    logic [7:0] next_data;
    logic       rise;
    logic       next_rise;

    // pins are asynchronous to clk_sys_i: two flops, then edge detection on s2 only
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1    <= 6'h3F;
            s2    <= 6'h3F;
            sck_q <= 1'b1;
            cs_q  <= 1'b1;
        end
        else
        begin
            s1    <= {spi_io_i, spi_cs_n_i, spi_sck_i};
            s2    <= s1;
            sck_q <= s2[0];
            cs_q  <= s2[1];
        end
    end

    always_comb
    begin
        next_sh   = sh;
        next_bits = bits;
        next_vld  = 1'b0;
        next_data = data;
        next_rise = s2[1] & ~cs_q;
        if (s2[1])
            next_bits = 4'h0;
        else if (s2[0] && !sck_q)
        begin
            if (bus.quad)
            begin
                next_sh   = {sh[3:0], s2[5:2]};
                next_bits = bits + 4'h4;
            end
            else
            begin
                next_sh   = {sh[6:0], s2[2]};
                next_bits = bits + 4'h1;
            end
            if (next_bits == 4'h8)
            begin
                next_vld  = 1'b1;
                next_data = next_sh;
                next_bits = 4'h0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sh   <= 8'h00;
            bits <= 4'h0;
            vld  <= 1'b0;
            data <= 8'h00;
            rise <= 1'b0;
        end
        else
        begin
            sh   <= next_sh;
            bits <= next_bits;
            vld  <= next_vld;
            data <= next_data;
            rise <= next_rise;
        end
    end

    assign bus.byte_vld = vld;
    assign bus.rx_byte  = data;
    assign bus.cs_act   = ~s2[1];
    assign bus.cs_rise  = rise;
endmodule : sfep_spi_rx
